// ==== logic/acrd_clock_rate.sv ====
`timescale 1ns/10ps
// Functional notes
// [RL1] async source code selects input one/two, loop one/two, port bit clocks; reset 0101
// [RL2] two async rate selects, 5 bits, reset 10001, standard rate coding
// [RL3] async rate status read-only, resets to zero, same coding
// [RL4] each output clock runs only while its bit 15 enable is set
// [RL5] system output divider at bits 7:3, codes 0 and 1 divide by 1
// [RL6] async output divider, same coding, reset zero
// [RL7] output source frequency select 000..011, higher codes reserved
// [RL8] rate codes 01XXX switch source frequencies to the 44.1 kHz family
// [RL9] software keeps system output source frequency at or below system clock
// [RL10] software keeps async output source frequency at or below async clock
// [RL11] rate detection runs only while bit 0 enable is set
// [RL12] detection source bits 3:1 pick a port frame clock; 110, 111 reserved
// [RL13] startup bit 0 suppresses trigger on first detection; 1 triggers always
// [RL14] four candidate rates A to D, 5 bits, reset zero, compared to measurement
// [RL15] software locks a slave port's domain to its external frame clock
// [RL16] port clocks driven in master mode, received in slave mode, mixed allowed
// [RL17] port clocks synchronised into the core clock before use
// [RL18] software enables async clock only after its source runs
// [RL19] output dividers restart on enable or divide change, no runt pulses; code cuts the running phase and restarts at count zero with output low
module acrd_clock_rate
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire acrd_pkg::acrd_bus_req_type   bus_req,
  output logic [15:0]                       bus_rdata,
  input  wire logic [4:0]                   sys_sample_rate_code,
  output logic [3:0]                        async_clock_source_sel,
  output logic                              async_clock_source_valid,
  output logic                              async_clock_enable,
  output acrd_pkg::acrd_src_freq_type       async_clock_freq,
  output logic                              sys_output_clock,
  output acrd_pkg::acrd_src_freq_type       sys_output_source_freq,
  output logic                              async_output_clock,
  output acrd_pkg::acrd_src_freq_type       async_output_source_freq,
  input  wire logic [5:0]                   detect_frame_clock_pins,
  output logic                              seq_trigger,
  input  wire acrd_pkg::acrd_port_clk_type  port_clk_in,
  input  wire acrd_pkg::acrd_port_clk_type  port_clk_gen,
  input  wire logic [2:0]                   port_master,
  output acrd_pkg::acrd_port_clk_type       port_clk_out,
  output acrd_pkg::acrd_port_clk_type       port_clk_oe,
  output acrd_pkg::acrd_port_clk_type       port_clk_sync,
  output logic                              clock_input_two_pulldown,
  output logic                              clock_input_one_pulldown
);

  localparam int MEAS_W = acrd_pkg::MEAS_W;
  localparam logic [MEAS_W-1:0] MEAS_MAX = '1;

  typedef struct packed {
    logic [3:0]            src;
    logic                  async_ena;
    logic [2:0]            async_freq;
    logic [4:0]            rate_one;
    logic [4:0]            rate_two;
    logic                  sys_ena;
    logic [4:0]            sys_div;
    logic [2:0]            sys_sel;
    logic                  as_ena;
    logic [4:0]            as_div;
    logic [2:0]            as_sel;
    logic                  est_ena;
    logic [2:0]            est_src;
    logic                  est_trig;
    logic [3:0][4:0]       cand;
    logic                  pd_two;
    logic                  pd_one;
    logic [15:0]           rdata;
    logic [4:0]            sys_cnt;
    logic                  sys_out;
    logic [5:0]            sys_last;
    logic [4:0]            as_cnt;
    logic                  as_out;
    logic [5:0]            as_last;
    logic [5:0]            frm_s1;
    logic [5:0]            frm_s2;
    logic                  frm_prev;
    logic [MEAS_W-1:0]     meas_cnt;
    logic                  edge_seen;
    logic [4:0]            det_code;
    logic                  det_valid;
    logic                  trig;
    logic [5:0]            pin_s1;
    logic [5:0]            pin_s2;
    logic [5:0]            port_out;
  } acrd_state_type;

  acrd_state_type s_q;
  acrd_state_type s_d;

  function automatic logic [4:0] div_value(input logic [4:0] code);
    div_value = (code < 5'h02) ? 5'h01 : code; // [RL5] [RL6]
  endfunction

  function automatic logic [MEAS_W-1:0] expected_period(input logic [4:0] code);
    int hz;
    hz = acrd_pkg::rate_hz(code);
    if (hz == 0)
      expected_period = '0;
    else
      expected_period = MEAS_W'((acrd_pkg::CLK_FREQ_HZ + hz / 2) / hz);
  endfunction

  function automatic logic rate_match(input logic [MEAS_W-1:0] meas,
                                      input logic [4:0]        code);
    logic [MEAS_W-1:0] exp_p;
    logic [MEAS_W-1:0] diff;
    exp_p = expected_period(code);
    diff  = (meas > exp_p) ? meas - exp_p : exp_p - meas;
    rate_match = (exp_p != '0) && (diff <= (exp_p >> acrd_pkg::TOL_SHIFT));
  endfunction

  // one divider step; restarts from zero with output low when its setting moves
  function automatic logic [5:0] div_step(input logic [4:0] cnt,
                                          input logic       ena,
                                          input logic [4:0] code,
                                          input logic       changed);
    logic [4:0] n;
    logic [4:0] nxt;
    n   = div_value(code);
    nxt = (cnt + 5'h01 >= n) ? 5'h00 : cnt + 5'h01;
    if (!ena || changed)
      div_step = 6'h00; // [RL4] [RL19]
    else
      div_step = {nxt, ({1'b0, nxt} < (({1'b0, n} + 6'h01) >> 1))};
  endfunction

  logic [4:0] sys_div_new;
  logic [4:0] as_div_new;
  logic       sys_chg;
  logic       as_chg;
  logic       frm_sel;
  logic       frm_rise;
  logic [4:0] hit_code;
  logic       hit;

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    s_d.trig  = 1'b0;

    if (bus_req.wr)
    begin
      case (bus_req.addr)
        acrd_pkg::ASYNC_CLOCK_CONFIG_OFS:
        begin
          s_d.src        = bus_req.wdata[acrd_pkg::SRC_LSB +: 4]; // [RL1]
          s_d.async_ena  = bus_req.wdata[acrd_pkg::ASYNC_ENA_BIT];
          s_d.async_freq = bus_req.wdata[acrd_pkg::ASYNC_FREQ_LSB +: 3];
        end
        acrd_pkg::ASYNC_RATE_ONE_SELECT_OFS: s_d.rate_one = bus_req.wdata[4:0]; // [RL2]
        acrd_pkg::ASYNC_RATE_TWO_SELECT_OFS: s_d.rate_two = bus_req.wdata[4:0]; // [RL2]
        acrd_pkg::SYS_OUTPUT_CLOCK_CTRL_OFS:
        begin
          s_d.sys_ena = bus_req.wdata[acrd_pkg::OUT_ENA_BIT];
          s_d.sys_div = bus_req.wdata[acrd_pkg::OUT_DIV_LSB +: 5];
          s_d.sys_sel = bus_req.wdata[acrd_pkg::OUT_SEL_LSB +: 3];
        end
        acrd_pkg::ASYNC_OUTPUT_CLOCK_CTRL_OFS:
        begin
          s_d.as_ena = bus_req.wdata[acrd_pkg::OUT_ENA_BIT];
          s_d.as_div = bus_req.wdata[acrd_pkg::OUT_DIV_LSB +: 5];
          s_d.as_sel = bus_req.wdata[acrd_pkg::OUT_SEL_LSB +: 3];
        end
        acrd_pkg::RATE_ESTIMATOR_CTRL_OFS:
        begin
          s_d.est_ena  = bus_req.wdata[acrd_pkg::EST_ENA_BIT];
          s_d.est_src  = bus_req.wdata[acrd_pkg::EST_SRC_LSB +: 3];
          s_d.est_trig = bus_req.wdata[acrd_pkg::EST_TRIG_BIT];
        end
        acrd_pkg::DETECT_RATE_A_OFS: s_d.cand[0] = bus_req.wdata[4:0]; // [RL14]
        acrd_pkg::DETECT_RATE_B_OFS: s_d.cand[1] = bus_req.wdata[4:0]; // [RL14]
        acrd_pkg::DETECT_RATE_C_OFS: s_d.cand[2] = bus_req.wdata[4:0]; // [RL14]
        acrd_pkg::DETECT_RATE_D_OFS: s_d.cand[3] = bus_req.wdata[4:0]; // [RL14]
        acrd_pkg::PAD_CTRL_CLOCK_TWO_OFS: s_d.pd_two = bus_req.wdata[acrd_pkg::PD_TWO_BIT];
        acrd_pkg::PAD_CTRL_CLOCK_ONE_OFS: s_d.pd_one = bus_req.wdata[acrd_pkg::PD_ONE_BIT];
        default: ;
      endcase
    end

    if (bus_req.rd)
    begin
      case (bus_req.addr)
        acrd_pkg::ASYNC_CLOCK_CONFIG_OFS:
        begin
          s_d.rdata[acrd_pkg::SRC_LSB +: 4]        = s_q.src;
          s_d.rdata[acrd_pkg::ASYNC_ENA_BIT]       = s_q.async_ena;
          s_d.rdata[acrd_pkg::ASYNC_FREQ_LSB +: 3] = s_q.async_freq;
        end
        acrd_pkg::ASYNC_RATE_ONE_SELECT_OFS: s_d.rdata[4:0] = s_q.rate_one;
        acrd_pkg::ASYNC_RATE_TWO_SELECT_OFS: s_d.rdata[4:0] = s_q.rate_two;
        // status shows the rate in force, none while the async clock enable bit is clear
        acrd_pkg::ASYNC_RATE_ONE_STATUS_OFS:
          s_d.rdata[4:0] = s_q.async_ena ? s_q.rate_one : acrd_pkg::RATE_STS_RESET; // [RL3]
        acrd_pkg::ASYNC_RATE_TWO_STATUS_OFS:
          s_d.rdata[4:0] = s_q.async_ena ? s_q.rate_two : acrd_pkg::RATE_STS_RESET; // [RL3]
        acrd_pkg::SYS_OUTPUT_CLOCK_CTRL_OFS:
        begin
          s_d.rdata[acrd_pkg::OUT_ENA_BIT]      = s_q.sys_ena;
          s_d.rdata[acrd_pkg::OUT_DIV_LSB +: 5] = s_q.sys_div;
          s_d.rdata[acrd_pkg::OUT_SEL_LSB +: 3] = s_q.sys_sel;
        end
        acrd_pkg::ASYNC_OUTPUT_CLOCK_CTRL_OFS:
        begin
          s_d.rdata[acrd_pkg::OUT_ENA_BIT]      = s_q.as_ena;
          s_d.rdata[acrd_pkg::OUT_DIV_LSB +: 5] = s_q.as_div;
          s_d.rdata[acrd_pkg::OUT_SEL_LSB +: 3] = s_q.as_sel;
        end
        acrd_pkg::RATE_ESTIMATOR_CTRL_OFS:
        begin
          s_d.rdata[acrd_pkg::EST_ENA_BIT]      = s_q.est_ena;
          s_d.rdata[acrd_pkg::EST_SRC_LSB +: 3] = s_q.est_src;
          s_d.rdata[acrd_pkg::EST_TRIG_BIT]     = s_q.est_trig;
        end
        acrd_pkg::DETECT_RATE_A_OFS: s_d.rdata[4:0] = s_q.cand[0];
        acrd_pkg::DETECT_RATE_B_OFS: s_d.rdata[4:0] = s_q.cand[1];
        acrd_pkg::DETECT_RATE_C_OFS: s_d.rdata[4:0] = s_q.cand[2];
        acrd_pkg::DETECT_RATE_D_OFS: s_d.rdata[4:0] = s_q.cand[3];
        acrd_pkg::DETECTED_RATE_STATUS_OFS: s_d.rdata[5:0] = {s_q.det_valid, s_q.det_code};
        acrd_pkg::PAD_CTRL_CLOCK_TWO_OFS: s_d.rdata[acrd_pkg::PD_TWO_BIT] = s_q.pd_two;
        acrd_pkg::PAD_CTRL_CLOCK_ONE_OFS: s_d.rdata[acrd_pkg::PD_ONE_BIT] = s_q.pd_one;
        default: s_d.rdata = 16'h0000;
      endcase
    end

    // output dividers, both counted on the core clock
    sys_chg = {s_q.sys_ena, s_q.sys_div} != s_q.sys_last;
    as_chg  = {s_q.as_ena, s_q.as_div} != s_q.as_last;
    {sys_div_new, s_d.sys_out} = div_step(s_q.sys_cnt, s_q.sys_ena, s_q.sys_div, sys_chg); // [RL5]
    {as_div_new, s_d.as_out}   = div_step(s_q.as_cnt, s_q.as_ena, s_q.as_div, as_chg); // [RL6]
    s_d.sys_cnt  = sys_div_new;
    s_d.as_cnt   = as_div_new;
    s_d.sys_last = {s_q.sys_ena, s_q.sys_div};
    s_d.as_last  = {s_q.as_ena, s_q.as_div};

    // frame clock pins pass two flops before the estimator looks at them
    s_d.frm_s1 = detect_frame_clock_pins;
    s_d.frm_s2 = s_q.frm_s1;
    frm_sel    = (s_q.est_src <= acrd_pkg::EST_SRC_MAX) ? s_q.frm_s2[s_q.est_src] : 1'b0; // [RL12]
    frm_rise   = frm_sel && !s_q.frm_prev;
    s_d.frm_prev = frm_sel;

    hit      = 1'b0;
    hit_code = 5'h00;
    for (int i = 3; i >= 0; i--)
    begin
      // candidate A wins over B, C and D when several fit the period
      if (rate_match(s_q.meas_cnt, s_q.cand[i]))
      begin
        hit      = 1'b1;
        hit_code = s_q.cand[i]; // [RL14]
      end
    end

    if (!s_q.est_ena)
    begin
      s_d.meas_cnt  = '0; // [RL11]
      s_d.edge_seen = 1'b0;
      s_d.det_valid = 1'b0;
      s_d.det_code  = acrd_pkg::RATE_STS_RESET;
    end
    else if (frm_rise)
    begin
      s_d.meas_cnt  = '0;
      s_d.edge_seen = 1'b1;
      // first edge after enable has no full period behind it
      if (s_q.edge_seen && hit && (!s_q.det_valid || hit_code != s_q.det_code))
      begin
        s_d.det_code  = hit_code;
        s_d.det_valid = 1'b1;
        s_d.trig      = s_q.det_valid || s_q.est_trig; // [RL13]
      end
    end
    else if (s_q.meas_cnt != MEAS_MAX)
      s_d.meas_cnt = s_q.meas_cnt + 1'b1;

    // port clocks: sampled into the core clock in every mode, driven only as master
    s_d.pin_s1   = {port_clk_in.bclk, port_clk_in.lrclk};
    s_d.pin_s2   = s_q.pin_s1; // [RL17]
    s_d.port_out = {port_clk_gen.bclk, port_clk_gen.lrclk};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q            <= '0;
      s_q.src        <= acrd_pkg::ASYNC_SRC_RESET; // [RL1]
      s_q.async_freq <= acrd_pkg::ASYNC_FREQ_RESET;
      s_q.rate_one   <= acrd_pkg::RATE_SEL_RESET; // [RL2]
      s_q.rate_two   <= acrd_pkg::RATE_SEL_RESET;
      s_q.sys_div    <= acrd_pkg::DIV_RESET;
      s_q.as_div     <= acrd_pkg::DIV_RESET;
      s_q.sys_sel    <= acrd_pkg::SEL_RESET;
      s_q.as_sel     <= acrd_pkg::SEL_RESET;
      s_q.cand       <= {4{acrd_pkg::CAND_RESET}};
    end
    else
      s_q <= s_d;
  end

  always_comb
  begin
    async_clock_source_sel = s_q.src;
    case (s_q.src)
      acrd_pkg::SRC_CLOCK_INPUT_ONE,
      acrd_pkg::SRC_CLOCK_INPUT_TWO,
      acrd_pkg::SRC_LOCKED_LOOP_ONE,
      acrd_pkg::SRC_LOCKED_LOOP_TWO,
      acrd_pkg::SRC_PORT_ONE_BCLK,
      acrd_pkg::SRC_PORT_TWO_BCLK,
      acrd_pkg::SRC_PORT_THREE_BCLK: async_clock_source_valid = 1'b1; // [RL1]
      default:                       async_clock_source_valid = 1'b0;
    endcase
  end

  // a reserved code yields no valid clock; the enable is gated by it
  assign async_clock_enable = s_q.async_ena && async_clock_source_valid;

  // frequency family follows the governing rate code pattern 01xxx
  assign async_clock_freq.sel              = s_q.async_freq;
  assign async_clock_freq.family_44k       = s_q.rate_one[4:3] == acrd_pkg::FAMILY_44K; // [RL8]
  assign sys_output_source_freq.sel        = (s_q.sys_sel > acrd_pkg::SEL_MAX) ? acrd_pkg::SEL_RESET
                                                                               : s_q.sys_sel; // [RL7]
  assign sys_output_source_freq.family_44k = sys_sample_rate_code[4:3] == acrd_pkg::FAMILY_44K; // [RL8]
  assign async_output_source_freq.sel      = (s_q.as_sel > acrd_pkg::SEL_MAX) ? acrd_pkg::SEL_RESET
                                                                              : s_q.as_sel; // [RL7]
  assign async_output_source_freq.family_44k = s_q.rate_one[4:3] == acrd_pkg::FAMILY_44K; // [RL8]

  assign sys_output_clock   = s_q.sys_out; // [RL4]
  assign async_output_clock = s_q.as_out; // [RL4]
  assign seq_trigger        = s_q.trig;
  assign bus_rdata          = s_q.rdata;

  assign port_clk_out.bclk  = s_q.port_out[5:3];
  assign port_clk_out.lrclk = s_q.port_out[2:0];
  assign port_clk_oe.bclk   = port_master; // [RL16]
  assign port_clk_oe.lrclk  = port_master; // [RL16]
  assign port_clk_sync.bclk  = s_q.pin_s2[5:3];
  assign port_clk_sync.lrclk = s_q.pin_s2[2:0];

  assign clock_input_two_pulldown = s_q.pd_two;
  assign clock_input_one_pulldown = s_q.pd_one;

endmodule

// ==== pkg/acrd_pkg.sv ====
package acrd_pkg;

  // register offsets
  localparam logic [15:0] ASYNC_CLOCK_CONFIG_OFS      = 16'h0112;
  localparam logic [15:0] ASYNC_RATE_ONE_SELECT_OFS   = 16'h0113;
  localparam logic [15:0] ASYNC_RATE_TWO_SELECT_OFS   = 16'h0114;
  localparam logic [15:0] ASYNC_RATE_ONE_STATUS_OFS   = 16'h011b;
  localparam logic [15:0] ASYNC_RATE_TWO_STATUS_OFS   = 16'h011c;
  localparam logic [15:0] SYS_OUTPUT_CLOCK_CTRL_OFS   = 16'h0149;
  localparam logic [15:0] ASYNC_OUTPUT_CLOCK_CTRL_OFS = 16'h014a;
  localparam logic [15:0] RATE_ESTIMATOR_CTRL_OFS     = 16'h0152;
  localparam logic [15:0] DETECT_RATE_A_OFS           = 16'h0153;
  localparam logic [15:0] DETECT_RATE_B_OFS           = 16'h0154;
  localparam logic [15:0] DETECT_RATE_C_OFS           = 16'h0155;
  localparam logic [15:0] DETECT_RATE_D_OFS           = 16'h0156;
  localparam logic [15:0] DETECTED_RATE_STATUS_OFS    = 16'h0157;
  localparam logic [15:0] PAD_CTRL_CLOCK_TWO_OFS      = 16'h0c20;
  localparam logic [15:0] PAD_CTRL_CLOCK_ONE_OFS      = 16'h0c21;

  // field positions
  localparam int SRC_LSB      = 0;
  localparam int ASYNC_ENA_BIT = 6;
  localparam int ASYNC_FREQ_LSB = 8;
  localparam int OUT_ENA_BIT  = 15;
  localparam int OUT_DIV_LSB  = 3;
  localparam int OUT_SEL_LSB  = 0;
  localparam int EST_ENA_BIT  = 0;
  localparam int EST_SRC_LSB  = 1;
  localparam int EST_TRIG_BIT = 4;
  localparam int PD_TWO_BIT   = 13;
  localparam int PD_ONE_BIT   = 12;

  // values after reset
  localparam logic [3:0] ASYNC_SRC_RESET  = 4'h5;
  localparam logic [2:0] ASYNC_FREQ_RESET = 3'h3;
  localparam logic [4:0] RATE_SEL_RESET   = 5'h11;
  localparam logic [4:0] RATE_STS_RESET   = 5'h00;
  localparam logic [4:0] DIV_RESET        = 5'h00;
  localparam logic [2:0] SEL_RESET        = 3'h0;
  localparam logic [4:0] CAND_RESET       = 5'h00;

  // async clock sources
  localparam logic [3:0] SRC_CLOCK_INPUT_ONE = 4'h0;
  localparam logic [3:0] SRC_CLOCK_INPUT_TWO = 4'h1;
  localparam logic [3:0] SRC_LOCKED_LOOP_ONE = 4'h4;
  localparam logic [3:0] SRC_LOCKED_LOOP_TWO = 4'h5;
  localparam logic [3:0] SRC_PORT_ONE_BCLK   = 4'h8;
  localparam logic [3:0] SRC_PORT_TWO_BCLK   = 4'h9;
  localparam logic [3:0] SRC_PORT_THREE_BCLK = 4'ha;

  localparam logic [2:0] SEL_MAX      = 3'h3;
  localparam logic [2:0] EST_SRC_MAX  = 3'h5;
  localparam logic [1:0] FAMILY_44K   = 2'h1;

  // timing
  localparam int CLK_FREQ_HZ  = 25_000_000;
  localparam int MEAS_W       = 14;
  localparam int TOL_SHIFT    = 4;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } acrd_bus_req_type;

  typedef struct packed {
    logic [2:0] sel;
    logic       family_44k;
  } acrd_src_freq_type;

  typedef struct packed {
    logic [2:0] bclk;
    logic [2:0] lrclk;
  } acrd_port_clk_type;

  // rate in hz for each sample rate code, zero for none or reserved
  function automatic int rate_hz(input logic [4:0] code);
    case (code)
      5'h01:   rate_hz = 12000;
      5'h02:   rate_hz = 24000;
      5'h03:   rate_hz = 48000;
      5'h04:   rate_hz = 96000;
      5'h05:   rate_hz = 192000;
      5'h09:   rate_hz = 11025;
      5'h0a:   rate_hz = 22050;
      5'h0b:   rate_hz = 44100;
      5'h0c:   rate_hz = 88200;
      5'h0d:   rate_hz = 176400;
      5'h10:   rate_hz = 4000;
      5'h11:   rate_hz = 8000;
      5'h12:   rate_hz = 16000;
      default: rate_hz = 0;
    endcase
  endfunction

endpackage

// ==== verif/acrd_chk.sv ====
`timescale 1ns/10ps
module acrd_chk
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire acrd_pkg::acrd_bus_req_type  bus_req,
  input wire logic [15:0]                 bus_rdata,
  input wire logic [4:0]                  sys_sample_rate_code,
  input wire logic [3:0]                  async_clock_source_sel,
  input wire logic                        async_clock_source_valid,
  input wire logic                        async_clock_enable,
  input wire logic                        sys_output_clock,
  input wire acrd_pkg::acrd_src_freq_type sys_output_source_freq,
  input wire logic                        async_output_clock,
  input wire logic                        seq_trigger,
  input wire acrd_pkg::acrd_port_clk_type port_clk_in,
  input wire acrd_pkg::acrd_port_clk_type port_clk_gen,
  input wire logic [2:0]                  port_master,
  input wire acrd_pkg::acrd_port_clk_type port_clk_out,
  input wire acrd_pkg::acrd_port_clk_type port_clk_oe,
  input wire acrd_pkg::acrd_port_clk_type port_clk_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside its slot");
  AST_SRC_VALID: assert property (async_clock_source_valid == (async_clock_source_sel inside
    {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha})) else $error("source valid wrong");
  AST_ENA_VALID: assert property (async_clock_enable |-> async_clock_source_valid)
    else $error("async clock enabled on reserved source");
  AST_SYS_OFF: assert property (bus_req.wr && bus_req.addr == 16'h0149 && !bus_req.wdata[15]
    |-> ##2 (!sys_output_clock) [*3]) else $error("system output clock runs while off");
  AST_ASYNC_OFF: assert property (bus_req.wr && bus_req.addr == 16'h014a && !bus_req.wdata[15]
    |-> ##2 (!async_output_clock) [*3]) else $error("async output clock runs while off");
  AST_SEL_RANGE: assert property (sys_output_source_freq.sel <= 3'h3)
    else $error("reserved source frequency driven");
  AST_FAMILY: assert property (sys_output_source_freq.family_44k ==
    (sys_sample_rate_code[4:3] == 2'b01)) else $error("family flag wrong");
  AST_TRIG_PULSE: assert property (seq_trigger |=> !seq_trigger)
    else $error("trigger longer than one cycle");
  AST_OE: assert property (port_clk_oe == {port_master, port_master})
    else $error("port clock enable wrong");
  AST_OUT: assert property (port_clk_out == $past(port_clk_gen))
    else $error("port clock output wrong");
  AST_SYNC: assert property (port_clk_sync == $past(port_clk_in, 2))
    else $error("port clock sync wrong");
endmodule
bind acrd_clock_rate acrd_chk u_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .sys_sample_rate_code(sys_sample_rate_code),
  .async_clock_source_sel(async_clock_source_sel),
  .async_clock_source_valid(async_clock_source_valid),
  .async_clock_enable(async_clock_enable), .sys_output_clock(sys_output_clock),
  .sys_output_source_freq(sys_output_source_freq), .async_output_clock(async_output_clock),
  .seq_trigger(seq_trigger), .port_clk_in(port_clk_in), .port_clk_gen(port_clk_gen),
  .port_master(port_master), .port_clk_out(port_clk_out), .port_clk_oe(port_clk_oe),
  .port_clk_sync(port_clk_sync));

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  acrd_pkg::acrd_bus_req_type  bus_req = '0;
  logic [15:0]                 bus_rdata;
  logic [4:0]                  rate_code = 5'h00;
  logic [5:0]                  pins = 6'h00;
  acrd_pkg::acrd_port_clk_type pin_in = '0;
  acrd_pkg::acrd_port_clk_type pin_gen = '0;
  logic [2:0]                  master = 3'h0;
  logic [3:0]                  src_sel;
  logic                        src_valid, async_ena, sys_oclk, async_oclk, trig, pd_two, pd_one;
  acrd_pkg::acrd_src_freq_type async_freq, sys_freq, aout_freq;
  int                          num_errors = 0, tests_run = 0, trig_cnt = 0;
  logic [15:0] mask [logic [15:0]] = '{16'h0112: 16'h074f, 16'h0113: 16'h001f,
    16'h0114: 16'h001f, 16'h0149: 16'h80ff, 16'h014a: 16'h80ff, 16'h0152: 16'h001f,
    16'h0153: 16'h001f, 16'h0154: 16'h001f, 16'h0155: 16'h001f, 16'h0156: 16'h001f,
    16'h0c20: 16'h2000, 16'h0c21: 16'h1000};
  logic [15:0] model [logic [15:0]];
  logic [15:0] addrs [$] = {16'h0112, 16'h0113, 16'h0114, 16'h011b, 16'h011c, 16'h0149,
    16'h014a, 16'h0152, 16'h0153, 16'h0154, 16'h0155, 16'h0156, 16'h0157, 16'h0c20,
    16'h0c21, 16'h0200};
  acrd_clock_rate uut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sys_sample_rate_code(rate_code), .async_clock_source_sel(src_sel),
    .async_clock_source_valid(src_valid), .async_clock_enable(async_ena),
    .async_clock_freq(async_freq), .sys_output_clock(sys_oclk), .sys_output_source_freq(sys_freq),
    .async_output_clock(async_oclk), .async_output_source_freq(aout_freq),
    .detect_frame_clock_pins(pins), .seq_trigger(trig), .port_clk_in(pin_in),
    .port_clk_gen(pin_gen), .port_master(master), .port_clk_out(), .port_clk_oe(),
    .port_clk_sync(), .clock_input_two_pulldown(pd_two), .clock_input_one_pulldown(pd_one));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (trig === 1'b1)
      trig_cnt++;
    if (!rst)
    begin
      pin_in <= 6'($urandom);
      pin_gen <= 6'($urandom);
      master <= 3'($urandom);
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    if (mask.exists(a))
      model[a] = d & mask[a];
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk("read data", bus_rdata, e);
    @(posedge clk);
  endtask
  // status copies the select only while the async clock enable bit 6 is set
  function automatic logic [15:0] expv(input logic [15:0] a);
    if (a == 16'h011b || a == 16'h011c)
      return model[16'h0112][6] ? model[a - 16'h0008] : 16'h0000;
    return mask.exists(a) ? model[a] : 16'h0000;
  endfunction
  function automatic logic [2:0] fsel(input logic [15:0] r);
    return (r[2:0] > 3'h3) ? 3'h0 : r[2:0];
  endfunction
  function automatic logic oc(input logic [15:0] a);
    return (a == 16'h0149) ? sys_oclk : async_oclk;
  endfunction
  task automatic outs_check;
    logic [15:0] c;
    logic        v;
    logic        f;
    c = model[16'h0112];
    v = c[3:0] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha};
    f = model[16'h0113][4:3] == 2'b01;
    chk("source", {12'h0, src_sel}, {12'h0, c[3:0]});
    chk("enable", {14'h0, src_valid, async_ena}, {14'h0, v, v & c[6]});
    chk("async freq", {12'h0, async_freq}, {12'h0, c[10:8], f});
    chk("sys freq", {12'h0, sys_freq}, {12'h0, fsel(model[16'h0149]),
      rate_code[4:3] == 2'b01});
    chk("aout freq", {12'h0, aout_freq}, {12'h0, fsel(model[16'h014a]), f});
    chk("pulldown", {14'h0, pd_two, pd_one}, {14'h0, model[16'h0c20][13], model[16'h0c21][12]});
  endtask
  task automatic div_test(input logic [15:0] a, input int code);
    int   n, i = 1, h = 0, l = 0;
    logic q [$];
    n = (code < 2) ? 1 : code;
    wr(a, 16'h8000 | 16'(code << 3));
    repeat (2 * n + 40)
    begin
      @(posedge clk);
      #1;
      q.push_back(oc(a));
    end
    while (i < q.size() - 1 && !(q[i-1] === 1'b0 && q[i] === 1'b1))
      i++;
    if (n == 1)
      i = 4;
    while (i + h < q.size() && q[i+h] === 1'b1)
      h++;
    while (i + h + l < q.size() && q[i+h+l] === 1'b0)
      l++;
    chk("high cycles", 16'(h), 16'((n == 1) ? q.size() - 4 : (n + 1) / 2));
    chk("low cycles", 16'(l), 16'((n == 1) ? 0 : n / 2));
  endtask
  task automatic edges(input int pin, input int period, input int n);
    repeat (n)
    begin
      pins[pin] <= 1'b1;
      repeat (period / 2) @(posedge clk);
      pins[pin] <= 1'b0;
      repeat (period - period / 2) @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    results();
  end
  initial
  begin
    int codes [7];
    void'($urandom(32'h54912413));
    codes = '{0, 1, 2, 3, 7, 31, int'($urandom_range(4, 30))};
    model = '{16'h0112: 16'h0305, 16'h0113: 16'h0011, 16'h0114: 16'h0011, default: 16'h0000};
    foreach (mask[a])
      if (!model.exists(a))
        model[a] = 16'h0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (addrs[i])
      rd(addrs[i], expv(addrs[i]));
    outs_check();
    $display("test reset values done");
    repeat (3)
    begin
      rate_code <= 5'($urandom);
      foreach (addrs[i])
        wr(addrs[i], 16'($urandom));
      wr(16'h0152, 16'h0000);
      foreach (addrs[i])
        rd(addrs[i], expv(addrs[i]));
      outs_check();
    end
    for (int c = 0; c < 16; c++)
    begin
      wr(16'h0112, 16'h0040 | 16'(c));
      outs_check();
    end
    $display("test register access done");
    foreach (addrs[i])
      if (addrs[i] == 16'h0149 || addrs[i] == 16'h014a)
        foreach (codes[k])
          div_test(addrs[i], codes[k]);
    $display("test dividers done");
    wr(16'h0153, 16'h0003);
    wr(16'h0154, 16'h0011);
    wr(16'h0152, 16'h0015);
    edges(2, 521, 3);
    chk("triggers", 16'(trig_cnt), 16'h0001);
    rd(16'h0157, 16'h0023);
    edges(2, 3125, 3);
    edges(0, 521, 3);
    chk("triggers", 16'(trig_cnt), 16'h0002);
    rd(16'h0157, 16'h0031);
    wr(16'h0152, 16'h0004);
    edges(2, 521, 3);
    rd(16'h0157, 16'h0000);
    wr(16'h0152, 16'h0005);
    edges(2, 521, 3);
    chk("triggers", 16'(trig_cnt), 16'h0002);
    rd(16'h0157, 16'h0023);
    edges(2, 3125, 3);
    chk("triggers", 16'(trig_cnt), 16'h0003);
    $display("test rate detection done");
    results();
  end
endmodule
